// [hlie_top.sv]
// data link interrupt enable and status, apb slave, channel interrupt output
`timescale 1ns/10ps
`default_nettype none
module hlie_top (
	input wire logic CLK, // system clock, 125 MHz
	input wire logic RESETN, // async reset, active low
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb direction, 1 write
	input wire logic [11:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic TX_MSG_BEGIN, // pulse: transmit controller started a message
	input wire logic RX_MSG_BEGIN, // pulse: receive controller started a message
	input wire logic TX_MSG_DONE, // pulse: transmit controller finished a message
	input wire logic RX_MSG_DONE, // pulse: receive controller took a whole message
	input wire logic RX_BUF_FULL, // pulse: receive message buffer became full
	input wire logic FRAME_CHECK_FAIL, // pulse: frame check mismatch seen
	input wire logic RX_ABORT_SEQ, // pulse: seven consecutive ones seen
	input wire logic RX_FLAG_OCTET, // pulse: flag octet seen
	output logic CHAN_IRQ // channel interrupt request, active high
);
	logic [6:0] data_link_irq_enable_1_reg;
	logic [6:0] flags;
	logic [6:0] ev;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic irq_reg;
	logic access;
	logic done;
	logic status_clr;
	hlie_pkg::hlie_sel_type sel;

	function automatic hlie_pkg::hlie_sel_type decode(input logic [11:0] addr);
		if (addr == hlie_pkg::ENABLE_OFFSET) begin
			return hlie_pkg::HLIE_SEL_ENABLE;
		end else if (addr == hlie_pkg::STATUS_OFFSET) begin
			return hlie_pkg::HLIE_SEL_STATUS;
		end
		return hlie_pkg::HLIE_SEL_NONE;
	endfunction

	assign sel = decode(PADDR);
	assign access = PSEL & PENABLE;
	// one wait state: the access completes on its second cycle
	assign done = access & pready_reg;
	assign status_clr = done & ~PWRITE & (sel == hlie_pkg::HLIE_SEL_STATUS);

	// buffer full also counts as rx done
	always_comb begin
		ev = 7'h00;
		ev[hlie_pkg::TX_BEGIN_BIT] = TX_MSG_BEGIN;
		ev[hlie_pkg::RX_BEGIN_BIT] = RX_MSG_BEGIN;
		ev[hlie_pkg::TX_DONE_BIT] = TX_MSG_DONE;
		ev[hlie_pkg::RX_DONE_BIT] = RX_MSG_DONE | RX_BUF_FULL;
		ev[hlie_pkg::FCS_FAIL_BIT] = FRAME_CHECK_FAIL;
		ev[hlie_pkg::RX_ABORT_BIT] = RX_ABORT_SEQ;
		ev[hlie_pkg::RX_FLAG_BIT] = RX_FLAG_OCTET;
	end

	// latch events, clear on status read
	hlie_event_latch u_latch (
		.clk(CLK),
		.resetn(RESETN),
		.set_ev(ev),
		.clr(status_clr),
		.flags(flags)
	);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access & ~pready_reg;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			data_link_irq_enable_1_reg <= hlie_pkg::ENABLE_RESET;
		end else if (done & PWRITE & (sel == hlie_pkg::HLIE_SEL_ENABLE)) begin
			data_link_irq_enable_1_reg <= PWDATA[6:0];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (access & ~pready_reg) begin
			pslverr_reg <= (sel == hlie_pkg::HLIE_SEL_NONE);
			unique case (sel)
				hlie_pkg::HLIE_SEL_ENABLE: prdata_reg <= {25'h0000000, data_link_irq_enable_1_reg};
				hlie_pkg::HLIE_SEL_STATUS: prdata_reg <= {25'h0000000, flags};
				hlie_pkg::HLIE_SEL_NONE: prdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(flags & data_link_irq_enable_1_reg);
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign CHAN_IRQ = irq_reg;

	access_wait_a: assert property (@(posedge CLK) disable iff (!RESETN)
		access & ~PREADY |=> PREADY)
		else $error("ready did not follow the first access cycle");

	ready_once_a: assert property (@(posedge CLK) disable iff (!RESETN)
		PREADY |=> !PREADY)
		else $error("ready stood longer than one cycle");

	slverr_ready_a: assert property (@(posedge CLK) disable iff (!RESETN)
		PSLVERR |-> PREADY)
		else $error("error response without ready");

	unmapped_err_a: assert property (@(posedge CLK) disable iff (!RESETN)
		access & ~PREADY & (decode(PADDR) == hlie_pkg::HLIE_SEL_NONE) |=> PSLVERR)
		else $error("unmapped access without error response");

	mapped_ok_a: assert property (@(posedge CLK) disable iff (!RESETN)
		access & ~PREADY & (sel != hlie_pkg::HLIE_SEL_NONE) |=> !PSLVERR)
		else $error("mapped access answered with error");

	rdata_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!PREADY |-> PRDATA == 32'h0000_0000)
		else $error("read data not zero outside ready");

	tx_begin_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		TX_MSG_BEGIN & data_link_irq_enable_1_reg[hlie_pkg::TX_BEGIN_BIT] |=> ##1 CHAN_IRQ)
		else $error("tx begin did not raise the interrupt");

	tx_begin_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
		TX_MSG_BEGIN |=> flags[hlie_pkg::TX_BEGIN_BIT])
		else $error("tx begin did not set its flag");

	rx_begin_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_MSG_BEGIN & data_link_irq_enable_1_reg[hlie_pkg::RX_BEGIN_BIT] |=> ##1 CHAN_IRQ)
		else $error("rx begin did not raise the interrupt");

	tx_done_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		TX_MSG_DONE & data_link_irq_enable_1_reg[hlie_pkg::TX_DONE_BIT] |=> ##1 CHAN_IRQ)
		else $error("tx done did not raise the interrupt");

	rx_done_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_MSG_DONE & data_link_irq_enable_1_reg[hlie_pkg::RX_DONE_BIT] |=> ##1 CHAN_IRQ)
		else $error("rx done did not raise the interrupt");

	rx_done_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_MSG_DONE |=> flags[hlie_pkg::RX_DONE_BIT])
		else $error("rx done did not set its flag");

	fcs_fail_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		FRAME_CHECK_FAIL & data_link_irq_enable_1_reg[hlie_pkg::FCS_FAIL_BIT] |=> ##1 CHAN_IRQ)
		else $error("frame check fail did not raise the interrupt");

	abort_seq_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_ABORT_SEQ & data_link_irq_enable_1_reg[hlie_pkg::RX_ABORT_BIT] |=> ##1 CHAN_IRQ)
		else $error("abort sequence did not raise the interrupt");

	flag_octet_irq_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_FLAG_OCTET & data_link_irq_enable_1_reg[hlie_pkg::RX_FLAG_BIT] |=> ##1 CHAN_IRQ)
		else $error("flag octet did not raise the interrupt");

	enable_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
		done & PWRITE & (PADDR == hlie_pkg::ENABLE_OFFSET) |=> data_link_irq_enable_1_reg == $past(PWDATA[6:0]))
		else $error("enable write not stored");

	enable_keep_a: assert property (@(posedge CLK) disable iff (!RESETN)
		done & PWRITE & (sel != hlie_pkg::HLIE_SEL_ENABLE) |=> data_link_irq_enable_1_reg == $past(data_link_irq_enable_1_reg))
		else $error("enable changed by a write elsewhere");

	enable_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
		access & ~PREADY & (sel == hlie_pkg::HLIE_SEL_ENABLE) |=> PRDATA[6:0] == $past(data_link_irq_enable_1_reg))
		else $error("enable read returned wrong value");

	status_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
		access & ~PREADY & (sel == hlie_pkg::HLIE_SEL_STATUS) |=> PRDATA[6:0] == $past(flags))
		else $error("status read returned wrong value");

	status_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
		status_clr & (ev == 7'h00) |=> flags == 7'h00)
		else $error("status read did not clear flags");

	set_wins_a: assert property (@(posedge CLK) disable iff (!RESETN)
		status_clr |=> flags == $past(ev))
		else $error("event lost against status clear");

	event_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
		ev != 7'h00 |=> (flags & $past(ev)) == $past(ev))
		else $error("event did not set its flag");

	flag_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
		!status_clr |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without status read");

	buf_full_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
		RX_BUF_FULL |=> flags[hlie_pkg::RX_DONE_BIT])
		else $error("buffer full did not set rx done flag");

	irq_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN)
		(flags & data_link_irq_enable_1_reg) == 7'h00 |=> !CHAN_IRQ)
		else $error("interrupt without enabled flag");

	irq_raise_a: assert property (@(posedge CLK) disable iff (!RESETN)
		(flags & data_link_irq_enable_1_reg) != 7'h00 |=> CHAN_IRQ)
		else $error("enabled flag without interrupt");

	reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
		PREADY |-> PRDATA[31:7] == 25'h0000000)
		else $error("reserved read bits not zero");
endmodule
`default_nettype wire

// [hlie_pkg.sv]
// constants for the data link interrupt enable block
package hlie_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_EV = 7;
	localparam logic [11:0] ENABLE_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam int TX_BEGIN_BIT = 6;
	localparam int RX_BEGIN_BIT = 5;
	localparam int TX_DONE_BIT = 4;
	localparam int RX_DONE_BIT = 3;
	localparam int FCS_FAIL_BIT = 2;
	localparam int RX_ABORT_BIT = 1;
	localparam int RX_FLAG_BIT = 0;
	localparam logic [6:0] ENABLE_RESET = 7'h00;
	localparam logic [6:0] STATUS_RESET = 7'h00;
	typedef enum logic [1:0] {HLIE_SEL_NONE, HLIE_SEL_ENABLE, HLIE_SEL_STATUS} hlie_sel_type;
endpackage

// [hlie_event_latch.sv]
// sticky event flags with clear on read, set taking priority
`timescale 1ns/10ps
`default_nettype none
module hlie_event_latch (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic [6:0] set_ev, // event pulses
	input wire logic clr, // status read completed
	output logic [6:0] flags // latched flags
);
	logic [6:0] flags_reg;
	logic [6:0] flags_next;
	genvar i;
	generate
		for (i = 0; i < hlie_pkg::NUM_EV; i++) begin : g_flag
			assign flags_next[i] = set_ev[i] | (flags_reg[i] & ~clr);
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					flags_reg[i] <= hlie_pkg::STATUS_RESET[i];
				end else begin
					flags_reg[i] <= flags_next[i];
				end
			end
		end
	endgenerate
	assign flags = flags_reg;
endmodule
`default_nettype wire

// [test_hdlc_link_irq_enable.sv]
// self-checking bench for the data link interrupt enable block
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_link_irq_enable;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	// bit 7 stands for buffer full, which shares the rx done flag
	logic [7:0] ev = 8'h00;
	logic [31:0] rd;
	logic [31:0] wd;
	logic [6:0] en;
	logic err;
	int fails = 0;
	int n_compared = 0;
	int waits = 0;
	always #4 clk = ~clk;
	hlie_top hlie_top_i (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TX_MSG_BEGIN(ev[6]), .RX_MSG_BEGIN(ev[5]), .TX_MSG_DONE(ev[4]), .RX_MSG_DONE(ev[3]),
		.RX_BUF_FULL(ev[7]), .FRAME_CHECK_FAIL(ev[2]), .RX_ABORT_SEQ(ev[1]), .RX_FLAG_OCTET(ev[0]),
		.CHAN_IRQ(irq));
	function automatic logic [6:0] exp_flags(input logic [7:0] e);
		return e[6:0] | {3'b000, e[7], 3'b000};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		waits = 0;
		do begin
			@(posedge clk);
			waits++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// an idle edge keeps the next setup off this release
		@(posedge clk);
	endtask
	task automatic pulse(input logic [7:0] v);
		ev <= v;
		@(posedge clk);
		ev <= 8'h00;
		repeat (3) @(posedge clk);
	endtask
	task automatic round(input logic [7:0] v, input logic [31:0] d);
		apb(1'b1, hlie_pkg::ENABLE_OFFSET, d);
		en = d[6:0];
		apb(1'b0, hlie_pkg::ENABLE_OFFSET, 32'h00000000);
		chk(rd, {25'h0000000, en});
		chk(waits, 32'h00000002);
		pulse(v);
		chk({31'h0, irq}, {31'h0, |(exp_flags(v) & en)});
		apb(1'b0, hlie_pkg::STATUS_OFFSET, 32'h00000000);
		chk(rd, {25'h0000000, exp_flags(v)});
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
	endtask
	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h3b1d6618));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b0, hlie_pkg::ENABLE_OFFSET, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b0, hlie_pkg::STATUS_OFFSET, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h0, irq}, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			round(8'h01 << i, 32'hffffff80 | (32'h1 << (i == 7 ? 3 : i)));
			round(8'h01 << i, 32'h0000007f ^ (32'h1 << (i == 7 ? 3 : i)));
		end
		apb(1'b1, hlie_pkg::STATUS_OFFSET, 32'hffffffff);
		apb(1'b0, hlie_pkg::STATUS_OFFSET, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b1, 12'h008, 32'h0000007f);
		chk({31'h0, err}, 32'h00000001);
		apb(1'b0, 12'h008, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h0, err}, 32'h00000001);
		apb(1'b0, hlie_pkg::ENABLE_OFFSET, 32'h00000000);
		chk(rd, {25'h0000000, en});
		for (int n = 0; n < 40; n++) begin
			wd = $urandom;
			round(8'($urandom), wd);
		end
		end_sim();
	end
endmodule
`default_nettype wire
